//--- vcs_sequencer.sv
// Purpose: VCO calibration sequencer with zero-delay feedback selection
// Assumes: Register port writes are synchronous to clk; ref clock is a pin
// Notes:   Shadow registers become active only on the update bit
`timescale 1ns/100ps
`default_nettype none

// Summary of operation
// - Sequencer steps on divided reference clock
// - Autoload request calibrates after power-up load
// - Update bit moves shadow into active
// - Read-only done flag after sequence finishes
// - Sync, tune, release sync, close loop
// - Outputs resume without waiting for lock
// - Two-bit divider scales phase detector rate
// - Calibration lasts 4400 calibration clock cycles
// - No calibration on divider register changes
// - Mode 01 feeds channel 0 to N
// - Other channels need external mode plus select
// - Zero delay aligns edges, R/N delays
// - Mode 11 takes feedback from clock pins
// - Feedback select defaults to channel 0
module vcs_sequencer (
	input  wire logic                   clk,
	input  wire logic                   nrst,
	input  wire logic                   reference_input_clock,
	input  wire logic [9:0]             r_divide,
	input  wire logic                   autoload_cal_req,
	input  wire vcs_pkg::vcs_reg_req_t  reg_req,
	output logic [7:0]                  reg_rdata,
	output vcs_pkg::vcs_pll_ctl_t       pll_ctl,
	output logic                        cal_done,
	output logic                        cal_busy
);
	import vcs_pkg::*;

	function automatic logic hit(input logic [9:0] a, input logic [9:0] o);
		hit = (a == o);
	endfunction

	vcs_state_t  state;
	logic [7:0]  sh_cal_ctrl;
	logic [7:0]  sh_zd_sel;
	logic [7:0]  sh_vco_div;
	logic [7:0]  act_cal_ctrl;
	logic [7:0]  act_zd_sel;
	logic [7:0]  act_vco_div;
	logic        start_prev;
	logic        auto_pend;
	logic [2:0]  ref_sync;
	logic        ref_level;
	logic        ref_rise;
	logic [9:0]  r_cnt;
	logic [9:0]  r_ratio;
	logic        r_wrap;
	logic        pfd_tick;
	logic [3:0]  cdiv_cnt;
	logic [3:0]  cdiv_last;
	logic        cal_tick;
	logic [12:0] cal_cnt;
	logic        io_update;
	logic        start_edge;
	logic [1:0]  zd_mode;

	assign io_update = reg_req.wr && hit(reg_req.addr, OFS_UPDATE)
		&& reg_req.wdata[BIT_UPDATE];
	assign zd_mode = act_zd_sel[POS_ZD_MODE +: 2];

	// Shadow registers take host writes
	always_ff @(posedge clk or negedge nrst) begin
		if (!nrst) begin
			sh_cal_ctrl <= RST_CAL_CTRL;
			sh_zd_sel   <= RST_ZD_SEL;
			sh_vco_div  <= RST_VCO_DIV;
		end else if (reg_req.wr) begin
			if (hit(reg_req.addr, OFS_CAL_CTRL)) begin
				sh_cal_ctrl <= reg_req.wdata;
			end
			if (hit(reg_req.addr, OFS_ZD_SEL)) begin
				sh_zd_sel <= reg_req.wdata;
			end
			if (hit(reg_req.addr, OFS_VCO_DIV)) begin
				sh_vco_div <= reg_req.wdata;
			end
		end
	end

	// Active copies change only on the update strobe
	always_ff @(posedge clk or negedge nrst) begin
		if (!nrst) begin
			act_cal_ctrl <= RST_CAL_CTRL;
			act_zd_sel   <= RST_ZD_SEL;
			act_vco_div  <= RST_VCO_DIV;
		end else if (io_update) begin
			act_cal_ctrl <= sh_cal_ctrl;
			act_zd_sel   <= sh_zd_sel;
			act_vco_div  <= sh_vco_div;
		end
	end

	// Start fires on a 0-to-1 of the active bit only, so a
	// stuck-high bit needs the clear/update dance to rearm
	always_ff @(posedge clk or negedge nrst) begin
		if (!nrst) begin
			start_prev <= 1'b0;
		end else begin
			start_prev <= act_cal_ctrl[BIT_CAL_START];
		end
	end
	assign start_edge = act_cal_ctrl[BIT_CAL_START] && !start_prev;

	// Autoload request held until the sequencer can take it
	always_ff @(posedge clk or negedge nrst) begin
		if (!nrst) begin
			auto_pend <= 1'b0;
		end else if (autoload_cal_req) begin
			auto_pend <= 1'b1;
		end else if (state == ST_IDLE) begin
			auto_pend <= 1'b0;
		end
	end

	// Reference pin synchroniser; 2nd and 3rd stages compared
	always_ff @(posedge clk or negedge nrst) begin
		if (!nrst) begin
			ref_sync <= 3'h0;
		end else begin
			ref_sync <= {ref_sync[1:0], reference_input_clock};
		end
	end

	always_ff @(posedge clk or negedge nrst) begin
		if (!nrst) begin
			ref_level <= 1'b0;
		end else if (ref_sync[1] == ref_sync[2]) begin
			ref_level <= ref_sync[2];
		end
	end
	assign ref_rise = (ref_sync[1] == ref_sync[2]) && ref_sync[2] && !ref_level;

	// R counter gives the phase detector rate from the reference;
	// a zero setting divides by one rather than stalling the count
	assign r_ratio = (r_divide == 10'h000) ? R_DIV_RESET : r_divide;
	assign r_wrap  = (r_cnt + 10'h001) >= r_ratio;

	always_ff @(posedge clk or negedge nrst) begin
		if (!nrst) begin
			r_cnt <= 10'h000;
		end else if (ref_rise) begin
			if (r_wrap) begin
				r_cnt <= 10'h000;
			end else begin
				r_cnt <= r_cnt + 10'h001;
			end
		end
	end
	assign pfd_tick = ref_rise && r_wrap;

	// Calibration divider: 2, 4, 8 or 16
	assign cdiv_last = 4'((5'h02 << act_cal_ctrl[POS_CAL_DIV +: 2]) - 5'h01);

	always_ff @(posedge clk or negedge nrst) begin
		if (!nrst) begin
			cdiv_cnt <= 4'h0;
		end else if (pfd_tick) begin
			cdiv_cnt <= (cdiv_cnt >= cdiv_last) ? 4'h0 : cdiv_cnt + 4'h1;
		end
	end
	assign cal_tick = pfd_tick && (cdiv_cnt >= cdiv_last);

	// Sequencer; only host start or autoload launch it
	always_ff @(posedge clk or negedge nrst) begin
		if (!nrst) begin
			state <= ST_IDLE;
		end else begin
			case (state)
				ST_IDLE: begin
					if (start_edge || auto_pend) begin
						state <= ST_SYNC;
					end
				end
				ST_SYNC:  if (cal_tick) state <= ST_TUNE;
				ST_TUNE:  if (cal_tick && cal_cnt == CAL_LAST) state <= ST_REL;
				ST_REL:   state <= ST_CLOSE;
				ST_CLOSE: state <= ST_IDLE;
				default:  state <= ST_IDLE;
			endcase
		end
	end

	// Cycle count advances only in the tune state; cleared in idle
	always_ff @(posedge clk or negedge nrst) begin
		if (!nrst) begin
			cal_cnt <= 13'h0000;
		end else if (state == ST_IDLE) begin
			cal_cnt <= 13'h0000;
		end else if (cal_tick && state == ST_TUNE) begin
			cal_cnt <= cal_cnt + 13'h0001;
		end
	end

	// Done cleared at launch, set on the same edge the loop closes
	always_ff @(posedge clk or negedge nrst) begin
		if (!nrst) begin
			cal_done <= 1'b0;
		end else if (state == ST_IDLE && (start_edge || auto_pend)) begin
			cal_done <= 1'b0;
		end else if (state == ST_CLOSE) begin
			cal_done <= 1'b1;
		end
	end

	assign cal_busy = (state != ST_IDLE);

	// Loop stays open until the cycle after sync release; no wait for lock
	always_ff @(posedge clk or negedge nrst) begin
		if (!nrst) begin
			pll_ctl <= '0;
		end else begin
			pll_ctl.sync_hold   <= (state == ST_SYNC) || (state == ST_TUNE);
			pll_ctl.tune_en     <= (state == ST_TUNE);
			pll_ctl.loop_closed <= (state == ST_IDLE) || (state == ST_CLOSE);
			pll_ctl.fb_source   <= (zd_mode == ZD_EXTERNAL)
				? act_zd_sel[POS_ZD_FBSEL +: 2] : 2'h0;
			pll_ctl.ext_fb      <= (zd_mode == ZD_EXTERNAL);
			pll_ctl.n_from_ch   <= (zd_mode == ZD_INTERNAL)
				|| (zd_mode == ZD_EXTERNAL);
		end
	end

	// Readback returns the shadow for writable registers
	always_ff @(posedge clk or negedge nrst) begin
		if (!nrst) begin
			reg_rdata <= 8'h00;
		end else if (reg_req.rd) begin
			case (reg_req.addr)
				OFS_CAL_CTRL: reg_rdata <= sh_cal_ctrl;
				OFS_ZD_SEL:   reg_rdata <= sh_zd_sel;
				OFS_STATUS:   reg_rdata <= {1'b0, cal_done, 6'h00};
				OFS_VCO_DIV:  reg_rdata <= sh_vco_div;
				default:      reg_rdata <= 8'h00;
			endcase
		end
	end

	// Sequence order and length
	AST_TUNE_AFTER_SYNC: assert property (
		@(posedge clk) disable iff (!nrst)
		(state == ST_SYNC && cal_tick) |=> state == ST_TUNE)
		else $error("tune did not follow sync");
	AST_LAUNCH: assert property (
		@(posedge clk) disable iff (!nrst)
		(state == ST_IDLE && (start_edge || auto_pend))
		|=> state == ST_SYNC && !cal_done)
		else $error("launch did not enter sync with done low");
	AST_DONE_LOW_BUSY: assert property (
		@(posedge clk) disable iff (!nrst)
		(state == ST_TUNE) |-> !cal_done)
		else $error("done high during calibration");
	AST_TUNE_LEN: assert property (
		@(posedge clk) disable iff (!nrst)
		(state == ST_REL) |-> cal_cnt == 13'(CAL_CYCLES))
		else $error("tuning did not last the full tick count");
	AST_TUNE_BOUND: assert property (
		@(posedge clk) disable iff (!nrst)
		(state == ST_TUNE) |-> cal_cnt <= CAL_LAST)
		else $error("calibration exceeded cycle count");
	AST_COUNT_ON_TICK: assert property (
		@(posedge clk) disable iff (!nrst)
		(state == ST_TUNE && !cal_tick) |=> $stable(cal_cnt))
		else $error("tuning count moved without a calibration tick");
	AST_DONE_SETS: assert property (
		@(posedge clk) disable iff (!nrst)
		(state == ST_CLOSE) |=> cal_done ##0 state == ST_IDLE)
		else $error("done not set at end");
	AST_NO_SELF_START: assert property (
		@(posedge clk) disable iff (!nrst)
		(state == ST_IDLE && !start_edge && !auto_pend)
		|=> state == ST_IDLE)
		else $error("calibration started unrequested");

	// Register update path
	AST_UPDATE_XFER: assert property (
		@(posedge clk) disable iff (!nrst)
		io_update |=> act_cal_ctrl == $past(sh_cal_ctrl)
		&& act_zd_sel == $past(sh_zd_sel)
		&& act_vco_div == $past(sh_vco_div))
		else $error("update did not transfer");
	AST_HOLD_NO_UPDATE: assert property (
		@(posedge clk) disable iff (!nrst)
		!io_update |=> $stable(act_cal_ctrl))
		else $error("active control changed without update");

	// Output hold, release and feedback routing
	AST_SYNC_HELD: assert property (
		@(posedge clk) disable iff (!nrst)
		(state == ST_TUNE) |=> pll_ctl.sync_hold)
		else $error("sync not held while tuning");
	AST_RELEASE: assert property (
		@(posedge clk) disable iff (!nrst)
		(state == ST_REL) |=> !pll_ctl.sync_hold ##1 pll_ctl.loop_closed)
		else $error("outputs not released");
	AST_ZD_INT: assert property (
		@(posedge clk) disable iff (!nrst)
		(zd_mode == ZD_INTERNAL) |=> pll_ctl.n_from_ch
		&& pll_ctl.fb_source == 2'h0 && !pll_ctl.ext_fb)
		else $error("internal zero delay routing wrong");
	AST_ZD_EXT: assert property (
		@(posedge clk) disable iff (!nrst)
		(zd_mode == ZD_EXTERNAL) |=> pll_ctl.ext_fb && pll_ctl.n_from_ch)
		else $error("external zero delay routing wrong");
endmodule // vcs_sequencer
`default_nettype wire

//--- vcs_pkg.sv
// Purpose: Shared constants and types for the VCO calibration sequencer
// Assumes: Byte-wide register port, 10-bit register address
// Notes:   Offsets are ten-bit register addresses
`default_nettype none
package vcs_pkg;
	localparam logic [9:0] OFS_CAL_CTRL   = 10'h018;
	localparam logic [9:0] OFS_ZD_SEL     = 10'h01E;
	localparam logic [9:0] OFS_STATUS     = 10'h01F;
	localparam logic [9:0] OFS_VCO_DIV    = 10'h1E0;
	localparam logic [9:0] OFS_UPDATE     = 10'h232;
	localparam int         BIT_CAL_START  = 0;
	localparam int         POS_CAL_DIV    = 1;
	localparam int         POS_ZD_MODE    = 1;
	localparam int         POS_ZD_FBSEL   = 3;
	localparam int         BIT_CAL_DONE   = 6;
	localparam int         BIT_UPDATE     = 0;
	localparam logic [7:0] RST_CAL_CTRL   = 8'h06;
	localparam logic [7:0] RST_ZD_SEL     = 8'h00;
	localparam logic [7:0] RST_VCO_DIV    = 8'h00;
	localparam logic [1:0] ZD_INTERNAL    = 2'h1;
	localparam logic [1:0] ZD_EXTERNAL    = 2'h3;
	localparam int         CAL_CYCLES     = 4400;
	localparam logic [12:0] CAL_LAST      = 13'(CAL_CYCLES - 1);
	localparam logic [9:0] R_DIV_RESET    = 10'h001;

	typedef struct packed {
		logic       wr;
		logic       rd;
		logic [9:0] addr;
		logic [7:0] wdata;
	} vcs_reg_req_t;

	typedef struct packed {
		logic       sync_hold;
		logic       tune_en;
		logic       loop_closed;
		logic [1:0] fb_source;
		logic       ext_fb;
		logic       n_from_ch;
	} vcs_pll_ctl_t;

	typedef enum logic [4:0] {
		ST_IDLE  = 5'b00001,
		ST_SYNC  = 5'b00010,
		ST_TUNE  = 5'b00100,
		ST_REL   = 5'b01000,
		ST_CLOSE = 5'b10000
	} vcs_state_t;
endpackage
`default_nettype wire

//--- vcs_host_model.sv
// Purpose: Host model: reference source and register port master
// Assumes: Stable reference present from time zero
// Notes:   Strobes change on the falling clk edge only
`timescale 1ns/100ps
`default_nettype none
module vcs_host_model (
	output logic                  reference_input_clock,
	output vcs_pkg::vcs_reg_req_t reg_req,
	input  wire logic             clk,
	input  wire logic [7:0]       reg_rdata
);
	import vcs_pkg::*;
	// 20 ns period, four clk cycles per reference period
	initial reference_input_clock = 1'b0;
	always #10 reference_input_clock = ~reference_input_clock;
	initial reg_req = '0;
	// Released bus shows inverted values, never the last ones
	task automatic wr(input logic [9:0] a, input logic [7:0] d);
		@(negedge clk);
		reg_req = '{wr: 1'b1, rd: 1'b0, addr: a, wdata: d};
		@(negedge clk);
		reg_req = '{wr: 1'b0, rd: 1'b0, addr: ~a, wdata: ~d};
	endtask
	// Update copies shadows, so it always follows the data write
	task automatic upd();
		wr(OFS_UPDATE, 8'h01);
	endtask
	task automatic rd(input logic [9:0] a, output logic [7:0] d);
		@(negedge clk);
		reg_req = '{wr: 1'b0, rd: 1'b1, addr: a, wdata: 8'hA5};
		@(negedge clk);
		reg_req = '{wr: 1'b0, rd: 1'b0, addr: ~a, wdata: 8'h5A};
		@(negedge clk);
		d = reg_rdata;
	endtask
	// Time is compressed: divider field 0 keeps runs short; on a real
	// detector rate the host picks a divider giving under 6.25 MHz
	// Divider register never touched during calibration
endmodule // vcs_host_model
`default_nettype wire

//--- test_vcs_sequencer.sv
// Purpose: Self-checking bench for the calibration sequencer
// Assumes: r_divide 1, calibration divider field 0
// Notes:   Two full calibrations, about 71k clk cycles
`timescale 1ns/100ps
`default_nettype none
module test_vcs_sequencer;
	import vcs_pkg::*;
	logic         clk, nrst, ref_clk, autoload_cal_req, cal_done, cal_busy;
	logic [9:0]   r_divide;
	logic [7:0]   reg_rdata, d;
	vcs_reg_req_t reg_req;
	vcs_pll_ctl_t pll_ctl;
	int           n_fail = 0;
	int           n_checks = 0;
	localparam int EXP_CYC = CAL_CYCLES * 2 * 4;
	vcs_host_model host (.reference_input_clock(ref_clk), .reg_req(reg_req),
		.clk(clk), .reg_rdata(reg_rdata));
	vcs_sequencer dut (.clk(clk), .nrst(nrst), .reference_input_clock(ref_clk),
		.r_divide(r_divide), .autoload_cal_req(autoload_cal_req),
		.reg_req(reg_req), .reg_rdata(reg_rdata), .pll_ctl(pll_ctl),
		.cal_done(cal_done), .cal_busy(cal_busy));
	initial clk = 1'b0;
	always #2.5 clk = ~clk;
	task automatic check(input string nm, input logic [15:0] seen, exp);
		n_checks++;
		if (seen !== exp) begin
			n_fail++;
			$display("MISMATCH %s exp %h seen %h", nm, exp, seen);
		end
	endtask
	task automatic end_of_test();
		$display("checks %0d mismatches %0d", n_checks, n_fail);
		if (n_fail == 0 && n_checks > 0)
			$display("SIMULATION PASSED");
		else
			$display("SIMULATION FAILED");
		$finish;
	endtask
	task automatic t_reset();
		check("busy", cal_busy, 1'b0);
		check("loop", pll_ctl.loop_closed, 1'b1);
		host.rd(OFS_CAL_CTRL, d); check("ctrl", d, RST_CAL_CTRL);
		host.rd(OFS_ZD_SEL, d); check("zd", d, RST_ZD_SEL);
		host.rd(OFS_STATUS, d); check("done_rd", d[BIT_CAL_DONE], 1'b0);
		host.rd(OFS_UPDATE, d); check("upd_rd", d, 8'h00);
		host.rd(10'h3FF, d); check("unmapped", d, 8'h00);
		$display("test reset done");
	endtask
	task automatic t_zero_delay();
		host.wr(OFS_ZD_SEL, 8'h02);
		check("shadow", pll_ctl.n_from_ch, 1'b0);
		host.upd();
		@(negedge clk);
		check("int_n", pll_ctl.n_from_ch, 1'b1);
		check("int_ext", pll_ctl.ext_fb, 1'b0);
		check("int_src", pll_ctl.fb_source, 2'h0);
		host.wr(OFS_ZD_SEL, 8'h16);
		host.upd();
		@(negedge clk);
		check("ext_fb", pll_ctl.ext_fb, 1'b1);
		check("ext_src", pll_ctl.fb_source, 2'h2);
		host.wr(OFS_VCO_DIV, 8'h03);
		host.rd(OFS_VCO_DIV, d); check("vco", d, 8'h03);
		host.wr(OFS_STATUS, 8'hFF);
		host.rd(OFS_STATUS, d); check("ro", d[BIT_CAL_DONE], 1'b0);
		$display("test zero delay done");
	endtask
	// Launch expected by the last update; times it to done
	task automatic run_cal();
		realtime t0;
		int      cyc;
		t0 = $realtime;
		repeat (3) @(negedge clk);
		check("busy", cal_busy, 1'b1);
		check("done_lo", cal_done, 1'b0);
		repeat (1000) @(negedge clk);
		check("sync", pll_ctl.sync_hold, 1'b1);
		check("tune", pll_ctl.tune_en, 1'b1);
		check("open", pll_ctl.loop_closed, 1'b0);
		while (!cal_done && ($realtime - t0) < 200000.0)
			@(negedge clk);
		cyc = int'(($realtime - t0) / 5.0);
		check("len", cyc >= EXP_CYC - 2 && cyc <= EXP_CYC + 20, 1'b1);
		check("rel", pll_ctl.sync_hold, 1'b0);
		check("closed", pll_ctl.loop_closed, 1'b1);
		check("untune", pll_ctl.tune_en, 1'b0);
		host.rd(OFS_STATUS, d); check("done_rd", d[BIT_CAL_DONE], 1'b1);
	endtask
	task automatic t_cals();
		host.wr(OFS_CAL_CTRL, 8'h01);
		host.upd();
		run_cal();
		// Start bit still set: a plain update must not relaunch
		host.wr(OFS_CAL_CTRL, 8'h01);
		host.upd();
		repeat (4) @(negedge clk);
		check("no_relaunch", cal_busy, 1'b0);
		check("done_kept", cal_done, 1'b1);
		host.wr(OFS_CAL_CTRL, 8'h00);
		host.upd();
		host.wr(OFS_CAL_CTRL, 8'h01);
		host.upd();
		run_cal();
		$display("test calibrations done");
	endtask
	task automatic t_autoload();
		@(negedge clk);
		autoload_cal_req = 1'b1;
		@(negedge clk);
		autoload_cal_req = 1'b0;
		repeat (4) @(negedge clk);
		check("auto_busy", cal_busy, 1'b1);
		check("auto_done", cal_done, 1'b0);
		$display("test autoload done");
	endtask
	// Reset in mid-calibration must abort it and restore defaults
	task automatic t_reset_mid();
		@(negedge clk);
		nrst = 1'b0;
		@(negedge clk);
		check("rst_busy", cal_busy, 1'b0);
		check("rst_done", cal_done, 1'b0);
		check("rst_ctl", pll_ctl, 7'h00);
		check("rst_rdata", reg_rdata, 8'h00);
		nrst = 1'b1;
		@(negedge clk);
		check("rst_loop", pll_ctl.loop_closed, 1'b1);
		check("rst_hold", pll_ctl.sync_hold, 1'b0);
		check("rst_fb", pll_ctl.fb_source, 2'h0);
		repeat (4) @(negedge clk);
		check("rst_idle", cal_busy, 1'b0);
		host.rd(OFS_CAL_CTRL, d); check("rst_ctrl", d, RST_CAL_CTRL);
		$display("test mid-run reset done");
	endtask
	initial begin
		nrst = 1'b0;
		autoload_cal_req = 1'b0;
		r_divide = 10'h001;
		repeat (2) @(negedge clk);
		nrst = 1'b1;
		@(negedge clk);
		t_reset();
		t_zero_delay();
		t_cals();
		t_autoload();
		t_reset_mid();
		end_of_test();
	end
	initial begin
		#500000;
		n_fail++;
		end_of_test();
	end
endmodule // test_vcs_sequencer
`default_nettype wire
